// File: verilog/tdws_slave.sv
// Purpose: Receive-only two-wire slave feeding a dual 8-bit DAC output latch pair
// Assumes: linkClk free-running sampler for the bus; sys_clk drives the outputs
// Notes: Input latches survive a repeated START and are copied out, not cleared, at a STOP after a command byte
`timescale 1ns/1ps
module tdws_slave #(
	parameter bit FOUR_ADDR_PINS = 1'b0
) (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Bus sampling clock
	input wire logic linkClk,
	// Two-wire bus pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Address select pins
	input wire logic addrSelPin0,
	input wire logic addrSelPin1,
	input wire logic addrSelPin2,
	input wire logic addrSelPin3,
	// DAC codes and power state
	output logic [7:0] dacOutChannel0,
	output logic [7:0] dacOutChannel1,
	output logic powerDownBit
);
	logic linkRstMeta;
	logic linkRstN;
	logic sclF;
	logic sdaF;
	logic sclPrev;
	logic sdaPrev;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic byteDone;
	logic accept;
	logic addrMatch;
	logic [3:0] pinSync1;
	logic [3:0] pinSync2;
	logic [6:0] ownAddr;
	tdws_pkg::tdws_state_type state;
	logic [3:0] bitCnt;
	logic [7:0] shiftReg;
	logic ackActive;
	logic cmdSeen;
	logic cmdChan;
	logic skipNext;
	logic pendPd;
	logic [7:0] inLatch0;
	logic [7:0] inLatch1;
	tdws_pkg::tdws_update_type xferWord;
	logic xferTog;
	logic togMeta;
	logic togSync;
	logic togSeen;

	// Reset carried into the bus domain
	always_ff @(posedge linkClk) begin
		linkRstMeta <= nrst;
		linkRstN <= linkRstMeta;
	end

	tdws_spike_filter #(.CYCLES(tdws_pkg::FILT_CYCLES)) u_sclFilt (
		.clk(linkClk),
		.rstN(linkRstN),
		.lineIn(sclIn),
		.lineOut(sclF)
	);

	tdws_spike_filter #(.CYCLES(tdws_pkg::FILT_CYCLES)) u_sdaFilt (
		.clk(linkClk),
		.rstN(linkRstN),
		.lineIn(sdaIn),
		.lineOut(sdaF)
	);

	// Address pins are asynchronous straps, two flops before use
	always_ff @(posedge linkClk) begin
		pinSync1 <= {addrSelPin3, addrSelPin2, addrSelPin1, addrSelPin0};
		pinSync2 <= pinSync1;
	end

	// Two-pin parts use fixed ones in place of the upper select pins
	assign ownAddr = {tdws_pkg::ADDR_FIXED_HI,
		FOUR_ADDR_PINS ? pinSync2[3:2] : tdws_pkg::ADDR_FIXED_MID, pinSync2[1:0]};
	assign addrMatch = (shiftReg[7:1] == ownAddr) && !shiftReg[tdws_pkg::RW_BIT];

	// Edge history of filtered lines
	always_ff @(posedge linkClk) begin
		if (!linkRstN) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= sclF;
			sdaPrev <= sdaF;
		end
	end

	// Edges are from filtered levels only, so rate down to DC is fine
	assign sclRise = sclF && !sclPrev;
	assign sclFall = !sclF && sclPrev;
	assign startCond = sclF && sclPrev && sdaPrev && !sdaF;
	assign stopCond = sclF && sclPrev && !sdaPrev && sdaF;
	assign byteDone = sclFall && (bitCnt == tdws_pkg::BIT_CNT_ACK) && !ackActive;
	assign accept = (state == tdws_pkg::ST_ADDR) ? addrMatch :
		(state == tdws_pkg::ST_CMD || state == tdws_pkg::ST_DATA);

	// Bit counter and shifter, sampled on the rising clock edge
	always_ff @(posedge linkClk) begin
		if (!linkRstN || startCond) begin
			bitCnt <= tdws_pkg::BIT_CNT_ZERO;
			shiftReg <= '0;
		end else if (sclRise && bitCnt < tdws_pkg::BIT_CNT_ACK) begin
			shiftReg <= {shiftReg[6:0], sdaF};
			bitCnt <= bitCnt + tdws_pkg::BIT_CNT_ONE;
		end else if (sclFall && ackActive) begin
			bitCnt <= tdws_pkg::BIT_CNT_ZERO;
		end
	end

	// Acknowledge slot: pull low from end of bit eight to end of ninth clock
	always_ff @(posedge linkClk) begin
		if (!linkRstN || startCond || stopCond) begin
			ackActive <= 1'b0;
			sdaOe <= 1'b0;
		end else if (byteDone) begin
			ackActive <= 1'b1;
			sdaOe <= accept;
		end else if (sclFall && ackActive) begin
			ackActive <= 1'b0;
			sdaOe <= 1'b0;
		end
	end

	// Open drain: the driven level is always low
	always_ff @(posedge linkClk) begin
		sdaOut <= 1'b0;
	end

	// Byte sequencer
	always_ff @(posedge linkClk) begin
		if (!linkRstN) begin
			state <= tdws_pkg::ST_IDLE;
		end else if (startCond) begin
			state <= tdws_pkg::ST_ADDR;
		end else if (stopCond) begin
			state <= tdws_pkg::ST_IDLE;
		end else if (byteDone) begin
			case (state)
				tdws_pkg::ST_ADDR: begin
					state <= addrMatch ? tdws_pkg::ST_CMD : tdws_pkg::ST_IGNORE;
				end
				tdws_pkg::ST_CMD: begin
					state <= tdws_pkg::ST_DATA;
				end
				tdws_pkg::ST_DATA: begin
					state <= tdws_pkg::ST_CMD;
				end
				default: begin
					state <= state;
				end
			endcase
		end
	end

	// Command decode and input latches; a cut byte never reaches byteDone
	always_ff @(posedge linkClk) begin
		if (!linkRstN) begin
			inLatch0 <= tdws_pkg::LATCH_RESET;
			inLatch1 <= tdws_pkg::LATCH_RESET;
			cmdChan <= 1'b0;
			skipNext <= 1'b0;
			pendPd <= 1'b0;
			cmdSeen <= 1'b0;
		end else if (startCond) begin
			cmdSeen <= 1'b0;
		end else if (byteDone && state == tdws_pkg::ST_CMD) begin
			cmdSeen <= 1'b1;
			cmdChan <= shiftReg[tdws_pkg::CMD_CH_BIT];
			pendPd <= shiftReg[tdws_pkg::CMD_PD_BIT];
			skipNext <= shiftReg[tdws_pkg::CMD_RST_BIT];
			if (shiftReg[tdws_pkg::CMD_RST_BIT]) begin
				inLatch0 <= tdws_pkg::LATCH_RESET;
				inLatch1 <= tdws_pkg::LATCH_RESET;
			end
		end else if (byteDone && state == tdws_pkg::ST_DATA) begin
			skipNext <= 1'b0;
			if (!skipNext && !cmdChan) begin
				inLatch0 <= shiftReg;
			end
			if (!skipNext && cmdChan) begin
				inLatch1 <= shiftReg;
			end
		end
	end

	// Hand the latches over at STOP; words stay put until the next STOP
	always_ff @(posedge linkClk) begin
		if (!linkRstN) begin
			xferWord <= '0;
			xferTog <= 1'b0;
		end else if (stopCond && cmdSeen &&
			(state == tdws_pkg::ST_CMD || state == tdws_pkg::ST_DATA)) begin
			xferWord <= '{chan0: inLatch0, chan1: inLatch1, powerDown: pendPd};
			xferTog <= !xferTog;
		end
	end

	// Toggle crossing into the system domain
	always_ff @(posedge sys_clk) begin
		togMeta <= xferTog;
		togSync <= togMeta;
	end

	// Output latches load together, so both channels move at once
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			togSeen <= 1'b0;
			dacOutChannel0 <= tdws_pkg::LATCH_RESET;
			dacOutChannel1 <= tdws_pkg::LATCH_RESET;
			powerDownBit <= 1'b0;
		end else if (togSync != togSeen) begin
			togSeen <= togSync;
			dacOutChannel0 <= xferWord.chan0;
			dacOutChannel1 <= xferWord.chan1;
			powerDownBit <= xferWord.powerDown;
		end
	end

	property p_ackNine;
		@(posedge linkClk) disable iff (!linkRstN)
		(byteDone && accept && !startCond && !stopCond) |=> sdaOe;
	endproperty
	a_ackNine: assert property (p_ackNine) else $error("accepted byte not acknowledged");

	property p_ignoreQuiet;
		@(posedge linkClk) disable iff (!linkRstN)
		(state == tdws_pkg::ST_IGNORE || state == tdws_pkg::ST_IDLE) |-> !sdaOe;
	endproperty
	a_ignoreQuiet: assert property (p_ignoreQuiet) else $error("drove bus while unaddressed");

	property p_startRestart;
		@(posedge linkClk) disable iff (!linkRstN)
		startCond |=> (state == tdws_pkg::ST_ADDR && bitCnt == tdws_pkg::BIT_CNT_ZERO && !sdaOe);
	endproperty
	a_startRestart: assert property (p_startRestart) else $error("START did not restart");

	property p_stopUpdate;
		@(posedge linkClk) disable iff (!linkRstN)
		(stopCond && cmdSeen && state == tdws_pkg::ST_DATA) |=> (xferTog != $past(xferTog));
	endproperty
	a_stopUpdate: assert property (p_stopUpdate) else $error("STOP did not hand over");

	property p_bitCount;
		@(posedge linkClk) disable iff (!linkRstN)
		(sclRise && bitCnt < tdws_pkg::BIT_CNT_ACK && !startCond)
			|=> (bitCnt == $past(bitCnt) + tdws_pkg::BIT_CNT_ONE);
	endproperty
	a_bitCount: assert property (p_bitCount) else $error("bit counter did not advance");

	property p_sampleHigh;
		@(posedge linkClk) disable iff (!linkRstN)
		(sclRise && bitCnt < tdws_pkg::BIT_CNT_ACK && !startCond) |=> (shiftReg[0] == $past(sdaF));
	endproperty
	a_sampleHigh: assert property (p_sampleHigh) else $error("data bit not captured");

	property p_resetCmd;
		@(posedge linkClk) disable iff (!linkRstN)
		(byteDone && state == tdws_pkg::ST_CMD && shiftReg[tdws_pkg::CMD_RST_BIT] && !startCond)
			|=> (inLatch0 == tdws_pkg::LATCH_RESET && inLatch1 == tdws_pkg::LATCH_RESET && skipNext);
	endproperty
	a_resetCmd: assert property (p_resetCmd) else $error("reset command did not clear");

	property p_badAddr;
		@(posedge linkClk) disable iff (!linkRstN)
		(byteDone && state == tdws_pkg::ST_ADDR && !addrMatch && !startCond && !stopCond)
			|=> (state == tdws_pkg::ST_IGNORE && !sdaOe);
	endproperty
	a_badAddr: assert property (p_badAddr) else $error("mismatched address accepted");

	property p_neverHigh;
		@(posedge linkClk) disable iff (!linkRstN)
		sdaOe |-> (sdaOut == 1'b0);
	endproperty
	a_neverHigh: assert property (p_neverHigh) else $error("data line driven high");

	property p_outputsLoad;
		@(posedge sys_clk) disable iff (!nrst)
		(togSync != togSeen) |=> (powerDownBit == $past(xferWord.powerDown)
			&& dacOutChannel0 == $past(xferWord.chan0));
	endproperty
	a_outputsLoad: assert property (p_outputsLoad) else $error("outputs did not load");
endmodule : tdws_slave

// File: verilog/tdws_pkg.sv
// Purpose: Shared constants and types for the two-wire DAC write slave
// Assumes: Bus front end sampled by a free-running link clock of known period
// Notes: Command byte layout is reserved[7:5], reset, power-down, unused[2:1], channel
package tdws_pkg;
	// Bus timing; a spike just under the limit may hit two samples, so ask for one more
	localparam int SPIKE_NS = 50;
	localparam int LINK_PERIOD_PS = 48000;
	localparam int FILT_CYCLES = (SPIKE_NS * 1000 - 1) / LINK_PERIOD_PS + 2;
	localparam int FILT_CNT_W = 4;
	// Byte framing
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BIT_CNT_ACK = 4'h8;
	localparam logic [3:0] BIT_CNT_ONE = 4'h1;
	localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
	// Address layout
	localparam logic [2:0] ADDR_FIXED_HI = 3'h2;
	localparam logic [1:0] ADDR_FIXED_MID = 2'h3;
	localparam int RW_BIT = 0;
	// Command byte fields
	localparam int CMD_RST_BIT = 4;
	localparam int CMD_PD_BIT = 3;
	localparam int CMD_CH_BIT = 0;
	localparam logic [7:0] LATCH_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_CMD = 3'b010,
		ST_DATA = 3'b011,
		ST_IGNORE = 3'b100
	} tdws_state_type;

	// Words handed from the bus domain to the output domain at STOP
	typedef struct packed {
		logic [7:0] chan0;
		logic [7:0] chan1;
		logic powerDown;
	} tdws_update_type;
endpackage : tdws_pkg

// File: verilog/tdws_spike_filter.sv
// Purpose: Two-flop synchroniser plus spike suppressor for one bus line
// Assumes: Runs on the link clock; line idles high
// Notes: Output follows the line only after it holds a new level for CYCLES clocks
`timescale 1ns/1ps
module tdws_spike_filter #(
	parameter int CYCLES = tdws_pkg::FILT_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstN,
	// Line
	input wire logic lineIn,
	output logic lineOut
);
	logic meta;
	logic sync;
	logic [tdws_pkg::FILT_CNT_W-1:0] cnt;

	// Synchroniser, first flop read only by the second
	always_ff @(posedge clk) begin
		meta <= lineIn;
		sync <= meta;
	end

	// Count cycles that differ from the output; a short spike resets the count and is lost
	always_ff @(posedge clk) begin
		if (!rstN) begin
			cnt <= '0;
			lineOut <= 1'b1;
		end else if (sync == lineOut) begin
			cnt <= '0;
		end else if (cnt == (tdws_pkg::FILT_CNT_W)'(CYCLES - 1)) begin
			cnt <= '0;
			lineOut <= sync;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	property p_spikeFilter;
		@(posedge clk) disable iff (!rstN)
		(lineOut != $past(lineOut)) |-> ($past(sync, 1) == lineOut && $past(sync, 2) == lineOut
			&& $past(sync, 3) == lineOut);
	endproperty
	a_spikeFilter: assert property (p_spikeFilter) else $error("filter passed a short pulse");
endmodule : tdws_spike_filter

// File: verif/tdws_bus_master.sv
// Purpose: Behavioural two-wire master for the DAC write slave
// Assumes: Bench resolves the open-drain data wire with a pull-up
// Notes: Fixed slow fast-mode timing; never stretches, never reads
`timescale 1ns/1ps
module tdws_bus_master (
	// Bus drive
	output logic sclOut,
	output logic sdaLow,
	// Resolved data wire
	input wire logic sdaLine
);
	logic glitchOn;
	// Both lines released at power-up
	initial begin
		sclOut = 1'b1; // Idle high
		sdaLow = 1'b0;
		glitchOn = 1'b0;
	end
	// START from idle or as a repeated START
	task automatic start_cond();
		sdaLow = 1'b0;
		#1300 sclOut = 1'b1;
		#600 sdaLow = 1'b1; // Data falls, clock high
		#600 sclOut = 1'b0;
	endtask : start_cond
	// STOP, then bus free time
	task automatic stop_cond();
		#300 sdaLow = 1'b1;
		#1000 sclOut = 1'b1;
		#600 sdaLow = 1'b0; // Data rises, clock high
		#1300;
	endtask : stop_cond
	// One byte plus the acknowledge clock
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#300 sdaLow = ~b[i]; // MSB first, data moves only with clock low
			#1000 sclOut = 1'b1;
			// Short clock dip that a working filter must swallow
			if (glitchOn && i == 4) begin
				#250 sclOut = 1'b0;
				#30 sclOut = 1'b1;
				#320;
			end else begin
				#600;
			end
			sclOut = 1'b0;
		end
		#300 sdaLow = 1'b0; // Release for the ninth clock
		#1000 sclOut = 1'b1;
		#300 ack = ~sdaLine;
		#300 sclOut = 1'b0;
	endtask : send_byte
endmodule : tdws_bus_master

// File: verif/tdws_slave_tb.sv
// Purpose: Self-checking bench for the two-wire DAC write slave
// Assumes: Two-pin address variant; straps 1,0 = 1,0
// Notes: Reset held longer than three cycles so the link domain sees it
`timescale 1ns/1ps
module tdws_slave_tb;
	logic sys_clk, nrst, linkClk, sclM, sdaLowM, sdaOut, sdaOe, sdaWire, ack, powerDownBit;
	logic [3:0] addrSel;
	logic [7:0] dacOutChannel0, dacOutChannel1, addr;
	int nErrors, samplesChecked, cycles;
	// Pull-up unless a party pulls low
	assign sdaWire = ~(sdaLowM | (sdaOe & ~sdaOut));
	assign addr = {3'h2, 2'h3, addrSel[1:0], 1'b0};
	tdws_slave i_tdws_slave (.sys_clk(sys_clk), .nrst(nrst), .linkClk(linkClk),
		.sclIn(sclM), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.addrSelPin0(addrSel[0]), .addrSelPin1(addrSel[1]), .addrSelPin2(addrSel[2]),
		.addrSelPin3(addrSel[3]), .dacOutChannel0(dacOutChannel0),
		.dacOutChannel1(dacOutChannel1), .powerDownBit(powerDownBit));
	tdws_bus_master i_tdws_bus_master (.sclOut(sclM), .sdaLow(sdaLowM), .sdaLine(sdaWire));
	// Clocks, unrelated in phase
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		linkClk = 1'b0;
		#7;
		forever #24 linkClk = ~linkClk;
	end
	task automatic end_sim();
		$display("checked %0d errors %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	task automatic chk1(input logic got, input logic exp);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8
	// Byte with its expected acknowledge
	task automatic sb(input logic [7:0] b, input logic expAck);
		i_tdws_bus_master.send_byte(b, ack);
		chk1(ack, expAck);
	endtask : sb
	task automatic chk_out(input logic [7:0] c0, input logic [7:0] c1, input logic pd);
		chk8(dacOutChannel0, c0);
		chk8(dacOutChannel1, c1);
		chk1(powerDownBit, pd);
	endtask : chk_out
	task automatic t_dual();
		i_tdws_bus_master.start_cond();
		sb(addr, 1'b1);
		sb(8'h00, 1'b1);
		sb(8'ha5, 1'b1);
		sb(8'h01, 1'b1);
		sb(8'h3c, 1'b1);
		chk_out(8'h00, 8'h00, 1'b0); // Nothing moves before STOP
		i_tdws_bus_master.stop_cond();
		chk_out(8'ha5, 8'h3c, 1'b0);
	endtask : t_dual
	task automatic t_power();
		i_tdws_bus_master.start_cond();
		sb(addr, 1'b1);
		sb(8'h08, 1'b1);
		i_tdws_bus_master.stop_cond();
		chk_out(8'ha5, 8'h3c, 1'b1); // Lone command sets power-down
		i_tdws_bus_master.start_cond();
		sb(addr, 1'b1);
		sb(8'h09, 1'b1);
		sb(8'h44, 1'b1);
		sb(8'h00, 1'b1);
		i_tdws_bus_master.stop_cond();
		chk_out(8'ha5, 8'h44, 1'b0); // Last command wins
	endtask : t_power
	task automatic t_reset();
		i_tdws_bus_master.start_cond();
		sb(addr, 1'b1);
		sb(8'h10, 1'b1);
		sb(8'h77, 1'b1); // Dropped byte is still acknowledged
		sb(8'h00, 1'b1);
		sb(8'h12, 1'b1);
		i_tdws_bus_master.stop_cond();
		chk_out(8'h12, 8'h00, 1'b0); // Cleared, dropped byte, later pair kept
	endtask : t_reset
	task automatic t_foreign();
		i_tdws_bus_master.start_cond();
		sb(addr ^ 8'h02, 1'b0); // Other strap value
		sb(8'h00, 1'b0);
		sb(8'hff, 1'b0);
		i_tdws_bus_master.stop_cond();
		i_tdws_bus_master.start_cond();
		sb(addr | 8'h01, 1'b0); // Read request refused
		i_tdws_bus_master.stop_cond();
		chk_out(8'h12, 8'h00, 1'b0);
	endtask : t_foreign
	task automatic t_restart();
		i_tdws_bus_master.start_cond();
		sb(addr, 1'b1);
		sb(8'h00, 1'b1);
		sb(8'h5a, 1'b1);
		i_tdws_bus_master.start_cond();
		sb(addr, 1'b1); // Reception restarts
		sb(8'h00, 1'b1);
		i_tdws_bus_master.stop_cond();
		chk_out(8'h5a, 8'h00, 1'b0); // Latches survive repeated START
	endtask : t_restart
	task automatic t_glitch();
		i_tdws_bus_master.glitchOn = 1'b1;
		i_tdws_bus_master.start_cond();
		sb(addr, 1'b1);
		sb(8'h01, 1'b1);
		sb(8'hc3, 1'b1);
		i_tdws_bus_master.stop_cond();
		i_tdws_bus_master.glitchOn = 1'b0;
		chk_out(8'h5a, 8'hc3, 1'b0);
	endtask : t_glitch
	// Open drain never drives high
	always @(posedge linkClk) begin
		if (sdaOe === 1'b1) begin
			chk1(sdaOut, 1'b0);
		end
	end
	// Hang guard, well above the expected run
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			nErrors++;
			end_sim();
		end
	end
	// Main sequence
	initial begin
		nErrors = 0;
		samplesChecked = 0;
		cycles = 0;
		nrst = 1'b0;
		addrSel = 4'h6;
		repeat (10) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (30) @(negedge sys_clk);
		chk_out(8'h00, 8'h00, 1'b0); // Nothing loaded before a STOP
		chk1(sdaOe, 1'b0); // Released while unaddressed
		t_dual();
		t_power();
		t_reset();
		t_foreign();
		t_restart();
		t_glitch();
		end_sim();
	end
endmodule : tdws_slave_tb
